// File: verilog/quad_phy_strap_and_speed_indicator.sv
/*
  dual-function strap / speed indicator pins of a four-port 10/100 transceiver,
  security mode signal redefinition, bused-mode lane sharing and an apb register pair.
  assumes a single clk_sys at 10 MHz, synchronous srst held three edges or more,
  and a controller on the same clock driving the mac-side inputs.
*/
// Behaviour
// - speed indicator pin high at 100 Mbit/s, low at 10 Mbit/s, per port
// - speed strap sampled at reset sets speed of all four ports together
// - floating or high speed strap gives 100 Mbit/s, low gives 10 Mbit/s
// - speed strap ignored while autonegotiation enabled; negotiated speed wins
// - effective speed is strap AND control speed-select bit
// - high security strap at reset enables security mode; default disabled
// - in security mode low-rate transmit enables act as security inputs
// - security input high makes port transmit jam instead of data
// - security mode merges both carriers and both collisions on high-rate pins
// - bused mode carries all 100 Mbit/s ports on shared port A mii
// - bused mode carries all 10 Mbit/s ports on shared port B serial
// - bused mode activates per-rate transmit and receive enables, low-rate transmit only outside security mode; carrier outputs do not depend on it
// - bused strap not pulled up gives per-port interfaces
`timescale 1ns/1ps
`include "quad_phy_params.svh"
module quad_phy_strap_and_speed_indicator import quad_phy_pkg::*; (
   input wire logic clk_sys,
   input wire logic srst,
   input wire apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] pin_in,
   output logic [3:0] pin_out,
   output logic [3:0] pin_oe,
   input wire logic [3:0] neg_speed_100,
   input wire logic [3:0] tx_enable_low_rate,
   input wire logic [3:0] tx_enable_high_rate,
   input wire logic [3:0] crs_low_in,
   input wire logic [3:0] crs_high_in,
   input wire logic [3:0] col_low_in,
   input wire logic [3:0] col_high_in,
   input wire mii_lane_t [3:0] rx_lane,
   output logic [3:0] port_speed_100,
   output logic [3:0] tx_jam,
   output logic [3:0] tx_route,
   output logic [3:0] carrier_sense_high_rate,
   output logic [3:0] carrier_sense_low_rate,
   output logic [3:0] col_high_rate,
   output logic [3:0] col_low_rate,
   output logic [3:0] rx_enable_high_rate,
   output logic [3:0] rx_enable_low_rate,
   output mii_lane_t [3:0] mii_out,
   output logic security_mode,
   output logic bused_mode
);
   logic [3:0] strap;
   logic [31:0] ctrl;
   logic [31:0] next_ctrl;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   phase_t phase;
   phase_t next_phase;
   logic [3:0] speed;
   logic [3:0] grant_hi;
   logic [3:0] grant_lo;
   mii_lane_t shared_hi;
   mii_lane_t shared_lo;
   logic [3:0] next_pin_out;
   logic [3:0] next_pin_oe;
   logic [3:0] next_jam;
   logic [3:0] next_route;
   logic [3:0] next_crs_hi;
   logic [3:0] next_crs_lo;
   logic [3:0] next_col_hi;
   logic [3:0] next_col_lo;
   logic [3:0] next_rxen_hi;
   logic [3:0] next_rxen_lo;
   mii_lane_t [3:0] next_mii;
   logic sec;
   logic bus;
   logic an_en;
   logic apb_access;
   logic hit_ctrl;
   logic hit_stat;
   logic apb_done;

   // ----------------------------------------
   // strap capture
   // ----------------------------------------
   strap_sampler u_strap (
      .clk_sys(clk_sys),
      .srst(srst),
      .pin_in(pin_in),
      .strap(strap)
   );

   assign sec = strap[`PIN_SECURE];
   assign bus = strap[`PIN_BUSED];
   assign an_en = ctrl[`CTRL_AN_BIT];

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   // one wait state so read data is a registered copy of current state
   assign apb_access = apb_req.psel & apb_req.penable & ~pready;
   assign hit_ctrl = apb_req.paddr == `CTRL_OFS;
   assign hit_stat = apb_req.paddr == `STAT_OFS;
   // writes land on the completing edge, so an access dropped before pready changes nothing
   assign apb_done = apb_req.psel & apb_req.penable & pready;

   always_comb begin
      next_ctrl = ctrl;
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      next_pready = apb_access;
      if (apb_access) begin
         if (hit_ctrl) begin
            next_prdata = ctrl;
         end else if (hit_stat) begin
            next_prdata[`STAT_STRAP_LSB +: 4] = strap;
            next_prdata[`STAT_SPEED_LSB +: 4] = port_speed_100;
            next_prdata[`STAT_RUN_BIT] = phase == PH_RUN;
         end else begin
            next_pslverr = 1'b1;
         end
      end
      if (apb_done && hit_ctrl && apb_req.pwrite) begin
         next_ctrl = 32'h0000_0000;
         next_ctrl[`CTRL_SPEED_BIT] = apb_req.pwdata[`CTRL_SPEED_BIT];
         next_ctrl[`CTRL_AN_BIT] = apb_req.pwdata[`CTRL_AN_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctrl <= `CTRL_RST;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ----------------------------------------
   // phase: straps while in reset, indicators afterwards
   // ----------------------------------------
   always_comb begin
      case (phase)
         PH_STRAP: next_phase = PH_RUN;
         PH_RUN: next_phase = PH_RUN;
         default: next_phase = PH_STRAP;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         phase <= PH_STRAP;
      end else begin
         phase <= next_phase;
      end
   end

   // ----------------------------------------
   // shared lanes for bused mode
   // ----------------------------------------
   logic [3:0] req_hi;
   logic [3:0] req_lo;

   generate
      for (genvar i = 0; i < `NPORTS; i++) begin : g_req
         assign speed[i] = an_en ? neg_speed_100[i] :
            (strap[`PIN_SPEED] & ctrl[`CTRL_SPEED_BIT]);
         assign req_hi[i] = speed[i] & rx_lane[i].dv;
         assign req_lo[i] = ~speed[i] & rx_lane[i].dv;
      end
   endgenerate

   lane_arbiter u_arb_hi (
      .req(req_hi),
      .lanes(rx_lane),
      .grant(grant_hi),
      .shared(shared_hi)
   );

   lane_arbiter u_arb_lo (
      .req(req_lo),
      .lanes(rx_lane),
      .grant(grant_lo),
      .shared(shared_lo)
   );

   // ----------------------------------------
   // mac-side signal redefinition
   // ----------------------------------------
   always_comb begin
      next_pin_oe = {4{phase == PH_RUN}};
      next_pin_out = speed;
      next_jam = sec ? tx_enable_low_rate : 4'h0;
      next_crs_hi = sec ? (crs_high_in | crs_low_in) : crs_high_in;
      next_crs_lo = sec ? 4'h0 : crs_low_in;
      next_col_hi = sec ? (col_high_in | col_low_in) : col_high_in;
      next_col_lo = sec ? 4'h0 : col_low_in;
      // low-rate enables are spent on security, so bused low-rate transmit is off then
      next_route = bus ? ((speed & tx_enable_high_rate) |
         (~speed & tx_enable_low_rate & {4{~sec}})) : 4'h0;
      next_rxen_hi = bus ? grant_hi : 4'h0;
      next_rxen_lo = bus ? grant_lo : 4'h0;
      if (bus) begin
         next_mii = '0;
         next_mii[0] = shared_hi;
         next_mii[1].dv = shared_lo.dv;
         next_mii[1].data = {3'h0, shared_lo.data[0]};
      end else begin
         next_mii = rx_lane;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pin_oe <= 4'h0;
         pin_out <= 4'h0;
         port_speed_100 <= 4'h0;
         tx_jam <= 4'h0;
         tx_route <= 4'h0;
         carrier_sense_high_rate <= 4'h0;
         carrier_sense_low_rate <= 4'h0;
         col_high_rate <= 4'h0;
         col_low_rate <= 4'h0;
         rx_enable_high_rate <= 4'h0;
         rx_enable_low_rate <= 4'h0;
         mii_out <= '0;
         security_mode <= 1'b0;
         bused_mode <= 1'b0;
      end else begin
         pin_oe <= next_pin_oe;
         pin_out <= next_pin_out;
         port_speed_100 <= speed;
         tx_jam <= next_jam;
         tx_route <= next_route;
         carrier_sense_high_rate <= next_crs_hi;
         carrier_sense_low_rate <= next_crs_lo;
         col_high_rate <= next_col_hi;
         col_low_rate <= next_col_lo;
         rx_enable_high_rate <= next_rxen_hi;
         rx_enable_low_rate <= next_rxen_lo;
         mii_out <= next_mii;
         security_mode <= sec;
         bused_mode <= bus;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   chk_ind_speed: assert property (an_en && !srst |=> pin_out == $past(neg_speed_100))
      else $error("indicator pins disagree with negotiated speed");
   chk_strap_hold: assert property (!$past(srst) |-> $stable(strap))
      else $error("strap changed outside reset");
   chk_speed_and: assert property (!an_en && !srst |=>
      port_speed_100 == {4{$past(strap[`PIN_SPEED] & ctrl[`CTRL_SPEED_BIT])}})
      else $error("speed is not strap and control bit");
   chk_an_ignore: assert property (an_en |=> port_speed_100 == $past(neg_speed_100))
      else $error("negotiated speed not applied");
   chk_sec_jam: assert property (sec && !srst |=> tx_jam == $past(tx_enable_low_rate))
      else $error("security input did not jam");
   chk_nosec_jam: assert property (!sec |=> tx_jam == 4'h0)
      else $error("jam outside security mode");
   chk_sec_crs: assert property (sec && !srst |=>
      (carrier_sense_high_rate & $past(crs_low_in)) == $past(crs_low_in))
      else $error("low-rate carrier missing on high-rate pin");
   chk_low_quiet: assert property (sec && !srst |=>
      (carrier_sense_low_rate | col_low_rate) == 4'h0)
      else $error("low-rate carrier or collision shown in security mode");
   chk_bused_share: assert property (bus && req_hi != 4'h0 |=>
      mii_out[0].dv && $onehot(rx_enable_high_rate))
      else $error("shared mii lane not granted");
   chk_bused_low: assert property (bus && req_lo != 4'h0 |=>
      mii_out[1].dv && $onehot(rx_enable_low_rate))
      else $error("shared serial lane not granted");
   chk_route_sec: assert property (bus && sec && !srst |=>
      tx_route == $past(speed & tx_enable_high_rate))
      else $error("bused transmit route wrong in security mode");
   chk_perport_off: assert property (!bus |=>
      (rx_enable_high_rate | rx_enable_low_rate | tx_route) == 4'h0)
      else $error("bused enables active in per-port mode");
   chk_oe_reset: assert property (disable iff (1'b0) srst |=> pin_oe == 4'h0)
      else $error("pins driven during reset");
   chk_apb_ready: assert property (apb_access |=> pready ##1 !pready)
      else $error("apb answer not one cycle");
   chk_ctrl_write: assert property (apb_done && hit_ctrl && apb_req.pwrite |=>
      ctrl[`CTRL_SPEED_BIT] == $past(apb_req.pwdata[`CTRL_SPEED_BIT]))
      else $error("control write did not land");

   cov_jam: cover property (sec ##1 tx_jam != 4'h0);
   cov_bused_hi: cover property (bus && req_hi != 4'h0 ##1 mii_out[0].dv);
   cov_bused_lo: cover property (bus && req_lo != 4'h0 ##1 mii_out[1].dv);
   cov_ten: cover property (!an_en && !strap[`PIN_SPEED] ##1 port_speed_100 == 4'h0);
   cov_autoneg: cover property (an_en ##1 port_speed_100 != 4'h0);
endmodule : quad_phy_strap_and_speed_indicator

// File: pkg/quad_phy_params.svh
/*
  offsets, field positions and reset values of the strap and speed indicator block.
  assumes inclusion by bare name from the package and the design modules.
*/
`ifndef QUAD_PHY_PARAMS_SVH
`define QUAD_PHY_PARAMS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define CTRL_OFS 12'h000
`define STAT_OFS 12'h004
`define CTRL_SPEED_BIT 13
`define CTRL_AN_BIT 12
`define CTRL_RST 32'h0000_2000

// ----------------------------------------
// status fields
// ----------------------------------------
`define STAT_STRAP_LSB 0
`define STAT_SPEED_LSB 4
`define STAT_RUN_BIT 8

// ----------------------------------------
// pin positions of the dual-function pins
// ----------------------------------------
`define PIN_ISOLATE 0
`define PIN_BUSED 1
`define PIN_SECURE 2
`define PIN_SPEED 3
`define NPORTS 4

`endif

// File: pkg/quad_phy_pkg.sv
/*
  types shared by the strap and speed indicator block.
  assumes the params header sits beside it on the include path.
*/
package quad_phy_pkg;
   `include "quad_phy_params.svh"

   typedef struct packed {
      logic dv;
      logic [3:0] data;
   } mii_lane_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef enum logic [1:0] {
      PH_STRAP = 2'b01,
      PH_RUN = 2'b10
   } phase_t;
endpackage : quad_phy_pkg

// File: verilog/strap_sampler.sv
/*
  two-flop synchroniser and strap latch for the dual-function pins.
  assumes srst is held for at least three clk_sys edges so the latch sees settled pins.
*/
`timescale 1ns/1ps
module strap_sampler import quad_phy_pkg::*; (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [3:0] pin_in,
   output logic [3:0] strap
);
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic [3:0] next_strap;

   // ----------------------------------------
   // synchroniser, no reset so values settle during reset
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      sync1 <= pin_in;
      sync2 <= sync1;
   end

   // ----------------------------------------
   // latch while reset, hold afterwards
   // ----------------------------------------
   always_comb begin
      next_strap = srst ? sync2 : strap;
   end

   always_ff @(posedge clk_sys) begin
      strap <= next_strap;
   end
endmodule : strap_sampler

// File: verilog/lane_arbiter.sv
/*
  picks the lowest-numbered requesting port and muxes its lane onto one shared lane.
  assumes requests and lanes come from logic on the same clock.
*/
`timescale 1ns/1ps
module lane_arbiter import quad_phy_pkg::*; (
   input wire logic [3:0] req,
   input wire mii_lane_t [3:0] lanes,
   output logic [3:0] grant,
   output mii_lane_t shared
);
   function automatic logic [3:0] lowest_one(input logic [3:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 3; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'h0;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction : lowest_one

   always_comb begin
      grant = lowest_one(req);
      shared = '0;
      for (int i = 0; i < 4; i++) begin
         if (grant[i]) begin
            shared = lanes[i];
         end
      end
   end
endmodule : lane_arbiter

// File: dv/mac_side_model.sv
/*
  behavioural controller on the mac side of the strap and speed indicator block.
  assumes the bench commands it on clk_sys and it answers one edge later.
*/
`timescale 1ns/1ps
module mac_side_model import quad_phy_pkg::*; (
   input wire logic clk_sys,
   input wire logic [3:0] sec_cmd,
   input wire logic [3:0] dv_cmd,
   input wire logic [3:0] car_lo,
   input wire logic [3:0] car_hi,
   input wire logic [3:0] nib,
   output logic [3:0] tx_enable_low_rate,
   output logic [3:0] tx_enable_high_rate,
   output logic [3:0] crs_low_in,
   output logic [3:0] crs_high_in,
   output logic [3:0] col_low_in,
   output logic [3:0] col_high_in,
   output mii_lane_t [3:0] rx_lane
);
   // ----------------------------------------
   // drive
   // ----------------------------------------
   // idle lanes show inverted data so a stale nibble is never mistaken for a frame
   always @(posedge clk_sys) begin
      tx_enable_low_rate <= sec_cmd;
      tx_enable_high_rate <= dv_cmd;
      crs_low_in <= car_lo;
      crs_high_in <= car_hi;
      col_low_in <= car_hi;
      col_high_in <= car_lo;
      for (int i = 0; i < 4; i++) begin
         rx_lane[i].dv <= dv_cmd[i];
         rx_lane[i].data <= dv_cmd[i] ? nib + 4'(i) : ~rx_lane[i].data;
      end
   end
endmodule : mac_side_model

// File: dv/tb_quad_phy_strap_and_speed_indicator.sv
/*
  self-checking bench: straps, speed indicators, security and bused modes, apb.
  assumes pin pulls as on the board: speed pin up, the others down.
*/
`timescale 1ns/1ps
module tb_quad_phy_strap_and_speed_indicator import quad_phy_pkg::*;;
   logic clk_sys = 0, srst = 1;
   apb_req_t apb_req = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic [3:0] pin_in, pin_out, pin_oe, strap_en = 0, strap_val = 0, neg_speed_100 = 0;
   logic [3:0] sec_cmd = 0, dv_cmd = 0, car_lo = 0, car_hi = 0, nib = 0;
   logic [3:0] tel, teh, cli, chi, oli, ohi, spd, jam, route, csh, csl, clh, cll, reh, rel;
   mii_lane_t [3:0] rx_lane, mii_out;
   logic sec, bus;
   int error_cnt = 0, samples_checked = 0;
   initial forever #50 clk_sys = ~clk_sys;
   // released pins fall to their pulls: speed up, the rest down
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & strap_en & strap_val)
      | (~pin_oe & ~strap_en & 4'h8);
   mac_side_model PM (.clk_sys, .sec_cmd, .dv_cmd, .car_lo, .car_hi, .nib,
      .tx_enable_low_rate(tel), .tx_enable_high_rate(teh), .crs_low_in(cli),
      .crs_high_in(chi), .col_low_in(oli), .col_high_in(ohi), .rx_lane);
   quad_phy_strap_and_speed_indicator DUT (.clk_sys, .srst, .apb_req, .prdata, .pready,
      .pslverr, .pin_in, .pin_out, .pin_oe, .neg_speed_100, .tx_enable_low_rate(tel),
      .tx_enable_high_rate(teh), .crs_low_in(cli), .crs_high_in(chi), .col_low_in(oli),
      .col_high_in(ohi), .rx_lane, .port_speed_100(spd), .tx_jam(jam), .tx_route(route),
      .carrier_sense_high_rate(csh), .carrier_sense_low_rate(csl), .col_high_rate(clh),
      .col_low_rate(cll), .rx_enable_high_rate(reh), .rx_enable_low_rate(rel), .mii_out,
      .security_mode(sec), .bused_mode(bus));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task report_and_stop;
      if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask : chk
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_sys) apb_req <= '{1'b1, 1'b0, wr, a, wd};
      @(posedge clk_sys) apb_req.penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         report_and_stop;
      end else begin
         rd = prdata;
         err = pslverr;
         apb_req <= '0;
      end
   endtask : apb
   // straps are held by the bench until one edge after reset ends, as on a board
   task do_reset(input logic [3:0] en, input logic [3:0] val);
      @(posedge clk_sys) begin
         strap_en <= en;
         strap_val <= val;
         srst <= 1'b1;
      end
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys) strap_en <= 4'h0;
      repeat (3) @(posedge clk_sys);
   endtask : do_reset
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      do_reset(4'h0, 4'h0);
      chk("speed", 32'hf, spd);
      chk("indicator", 32'hf, pin_out);
      chk("oe", 32'hf, pin_oe);
      chk("modes", 32'h0, {sec, bus});
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl", 32'h0000_2000, rd);
      apb(1'b0, 12'h004, 32'h0);
      chk("stat", 32'h0000_01f8, rd);
      apb(1'b1, 12'h008, 32'hffff_ffff);
      chk("slverr", 32'h1, err);
      apb(1'b1, 12'h000, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk("and speed", 32'h0, spd);
      chk("indicator 10", 32'h0, pin_out);
      neg_speed_100 <= 4'h5;
      apb(1'b1, 12'h000, 32'h0000_3000);
      repeat (2) @(posedge clk_sys);
      chk("autoneg", 32'h5, spd);
      chk("indicator an", 32'h5, pin_out);
      do_reset(4'he, 4'h6);
      chk("strap 10", 32'h0, spd);
      chk("modes", 32'h3, {sec, bus});
      apb(1'b0, 12'h004, 32'h0);
      chk("stat2", 32'h0000_0106, rd);
      sec_cmd <= 4'h2;
      car_lo <= 4'h1;
      car_hi <= 4'h4;
      nib <= 4'h5;
      dv_cmd <= 4'hc;
      repeat (3) @(posedge clk_sys);
      chk("jam", 32'h2, jam);
      chk("crs hi", 32'h5, csh);
      chk("crs lo", 32'h0, csl);
      chk("col hi", 32'h5, clh);
      chk("col lo", 32'h0, cll);
      chk("serial", 32'h3, {30'h0, mii_out[1].dv, mii_out[1].data[0]});
      chk("rx en", 32'h04, {24'h0, reh, rel});
      chk("route sec", 32'h0, route);
      neg_speed_100 <= 4'hf;
      apb(1'b1, 12'h000, 32'h0000_1000);
      repeat (3) @(posedge clk_sys);
      chk("shared mii", 32'h17, mii_out[0]);
      chk("rx en hi", 32'h40, {24'h0, reh, rel});
      chk("route hi", 32'hc, route);
      report_and_stop;
   end
endmodule : tb_quad_phy_strap_and_speed_indicator
